//--- hw/nic_arb_if.sv
/*
  Request bundle between the controller and a priority resolver.
  Assumes keys are packed NSRC fields of KW bits, smaller key wins.
*/
interface nic_arb_if #(parameter int N = 7, parameter int KW = 6);
  logic [N-1:0]         req;
  logic [N*KW-1:0]      key;
  logic                 valid;
  logic [$clog2(N)-1:0] idx;
  logic [KW-1:0]        best;
  modport src (output req, output key, input valid, input idx, input best);
  modport arb (input req, input key, output valid, output idx, output best);
endinterface

//--- hw/nic_arbiter.sv
/*
  Combinational priority resolver: picks the requesting entry with
  the smallest key. Assumes keys of distinct sources never tie.
*/
module nic_arbiter #(
  parameter int N  = 7,
  parameter int KW = 6
) (
  nic_arb_if.arb bus
);
  localparam int IW = $clog2(N);

  always_comb begin
    bus.valid = 1'b0;
    bus.idx   = '0;
    bus.best  = '0;
    for (int i = 0; i < N; i++) begin
      // Strictly smaller replaces, so equal keys keep the lower index
      if (bus.req[i] && (!bus.valid || bus.key[i*KW +: KW] < bus.best)) begin // RL11
        bus.valid = 1'b1; // RL13
        bus.idx   = IW'(i);
        bus.best  = bus.key[i*KW +: KW];
      end
    end
  end
endmodule

//--- hw/nic_ctrl.sv
/*
  Nested priority interrupt controller, top level with AXI4-Lite
  registers, pin synchronisers, nesting logic and cascade acknowledge.
  Assumes the core pulses ack_core once per interrupt while irq_core
  is high, and that external pins are asynchronous to mclk.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
// Overview of operation
// [RL1] Five external inputs: one non-maskable line and four general request pins.
// [RL2] General pins run direct, one cascade pair plus two direct, or two pairs.
// [RL3] A cascaded request takes its vector from the external controller.
// [RL4] Cascade acknowledge is two ack pulses; vector captured on the second.
// [RL5] Internal sources are handled the same way in every configuration.
// [RL6] Cascade mode bits live in the first and second external control registers.
// [RL7] Fully nested mode: four direct pins with internally made vectors.
// [RL8] An in-service flag blocks requests of lower priority from interrupting.
// [RL9] A source whose in-service flag is set cannot interrupt again.
// [RL10] Each control register holds a three bit priority level, 0 to 7.
// [RL11] Smaller priority value wins.
// [RL12] Sources reset to default levels; equal levels use a fixed order.
// [RL13] Among pending requests exactly one is chosen and offered to the core.
// [RL14] Higher priority requests may nest over a source still in service.
// [RL15] Internal sources blockable by own control bit or controller mask.
// [RL16] Relocation register bit 14 puts the controller into slave mode.
// [RL17] Default levels and tie order are design parameters.
// [RL18] Acknowledge sets the in-service flag; an end-of-interrupt write clears it.
module nic_ctrl
  import nic_pkg::*;
#(
  parameter logic [NSRC*PW-1:0] DEF_PRIO = 21'h1f_ffff, // RL17
  parameter logic [NSRC*PW-1:0] TIE_RANK = 21'h1a_c688, // RL17
  parameter logic [VW-1:0]      VEC_BASE = 8'h20,
  parameter logic [VW-1:0]      NMI_VEC  = 8'h02,
  parameter logic [VW-1:0]      SPUR_VEC = 8'hFF
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [DW-1:0] s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [DW-1:0]      s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          tmr_req,
  input  wire logic [1:0]    dma_req,
  input  wire logic          nmi_pin,
  input  wire logic [3:0]    gen_pin_in,
  output logic [1:0]         gen_pin_out,
  output logic [1:0]         gen_pin_oe,
  input  wire logic [VW-1:0] casc_vec_pin,
  output logic               irq_core,
  input  wire logic          ack_core,
  output logic [VW-1:0]      vec_out,
  output logic               vec_valid,
  output logic               int_out
);
  logic [SYW-1:0]  s1, s2, s3, filt;
  logic            nmi_d, nmi_pend;
  logic [PW-1:0]   prio [NSRC];
  logic [NSRC-1:0] src_off, imask, is_flag, req_raw, elig;
  logic [1:0]      casc;
  logic            slave;
  logic [NST-1:0]  stat, smask, ev;
  nic_state_t      state;
  logic [CNTW-1:0] cnt;
  logic            pair;
  logic            aw_hold, w_hold;
  logic [AW-1:0]   aw_a;
  logic [DW-1:0]   w_d;
  logic [3:0]      w_s;
  logic            wr_fire, grant, casc_sel, take, ack_act;
  logic [DW-1:0]   bm, w_new, w_one;
  logic [NSRC-1:0] is_set, is_clr;
  logic            nmi_f;
  logic [3:0]      gen_f;
  logic [VW-1:0]   cvec_f;
  logic [PW-1:0]   win_lvl, is_lvl;

  nic_arb_if #(.N(NSRC), .KW(KW)) pend_bus ();
  nic_arb_if #(.N(NSRC), .KW(KW)) is_bus ();

  nic_arbiter #(.N(NSRC), .KW(KW)) u_pend (.bus(pend_bus.arb));
  nic_arbiter #(.N(NSRC), .KW(KW)) u_insvc (.bus(is_bus.arb));

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Pin synchroniser; a bit changes only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      filt <= '0;
    end else begin
      s1   <= {casc_vec_pin, gen_pin_in, nmi_pin};
      s2   <= s1;
      s3   <= s2;
      filt <= ((s2 ~^ s3) & s2) | ((s2 ^ s3) & filt);
    end
  end

  assign nmi_f  = filt[SY_NMI];
  assign gen_f  = filt[SY_GEN +: 4];
  assign cvec_f = filt[SY_VEC +: VW];

  // Pins that serve as ack outputs in cascade mode never raise requests
  always_comb begin
    req_raw           = '0;
    req_raw[SRC_TMR]  = tmr_req;
    req_raw[SRC_DMA0] = dma_req[0];
    req_raw[SRC_DMA1] = dma_req[1];
    if (!slave) begin // RL16
      req_raw[SRC_EXT0] = gen_f[0]; // RL7
      req_raw[SRC_EXT1] = gen_f[1];
      req_raw[SRC_EXT2] = gen_f[2] & ~casc[0]; // RL2
      req_raw[SRC_EXT3] = gen_f[3] & ~casc[1]; // RL2
    end
  end

  // Same masking path for every source, whatever the pin configuration
  assign elig = req_raw & ~src_off & ~imask & ~is_flag; // RL5 RL9 RL15

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      pend_bus.key[i*KW +: KW] = {prio[i], TIE_RANK[i*PW +: PW]}; // RL12
    end
  end
  assign pend_bus.req = elig; // RL13
  assign is_bus.key   = pend_bus.key;
  assign is_bus.req   = is_flag;

  assign win_lvl = pend_bus.best[KW-1 -: PW];
  assign is_lvl  = is_bus.best[KW-1 -: PW];

  // Only a strictly better level nests over what is in service
  assign grant = pend_bus.valid && (!is_bus.valid || win_lvl < is_lvl); // RL8 RL14

  assign casc_sel = (pend_bus.idx == IDXW'(SRC_EXT0) && casc[0]) ||
                    (pend_bus.idx == IDXW'(SRC_EXT1) && casc[1]); // RL3
  assign take     = state == ST_IDLE && ack_core && !nmi_pend && grant;
  assign ack_act  = |gen_pin_out;

  // Acknowledge sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      pair        <= 1'b0;
      gen_pin_out <= '0;
      vec_out     <= '0;
      vec_valid   <= 1'b0;
    end else begin
      vec_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (ack_core) begin
            if (nmi_pend) begin
              vec_out   <= NMI_VEC; // RL1
              vec_valid <= 1'b1;
            end else if (grant && casc_sel) begin
              state             <= ST_ACK1; // RL4
              cnt               <= '0;
              pair              <= pend_bus.idx == IDXW'(SRC_EXT1);
              gen_pin_out[pend_bus.idx == IDXW'(SRC_EXT1)] <= 1'b1;
            end else if (grant) begin
              vec_out   <= VEC_BASE + VW'(pend_bus.idx); // RL7
              vec_valid <= 1'b1;
            end else begin
              vec_out   <= SPUR_VEC;
              vec_valid <= 1'b1;
            end
          end
        end
        ST_ACK1: begin
          cnt <= cnt + 1'b1;
          if (cnt == ACK_LEN - 1'b1) begin
            state             <= ST_GAP;
            cnt               <= '0;
            gen_pin_out[pair] <= 1'b0;
          end
        end
        ST_GAP: begin
          cnt <= cnt + 1'b1;
          if (cnt == ACK_GAP - 1'b1) begin
            state             <= ST_ACK2;
            cnt               <= '0;
            gen_pin_out[pair] <= 1'b1; // RL4
          end
        end
        ST_ACK2: begin
          cnt <= cnt + 1'b1;
          if (cnt == ACK_LEN - 1'b1) begin
            state             <= ST_IDLE;
            cnt               <= '0;
            gen_pin_out[pair] <= 1'b0;
            vec_out           <= cvec_f; // RL3 RL4
            vec_valid         <= 1'b1;
          end
        end
      endcase
    end
  end

  // Drops as soon as the core acknowledges, so one ack per request
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_core <= 1'b0;
    end else begin
      irq_core <= state == ST_IDLE && !ack_core && (nmi_pend || grant); // RL13
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gen_pin_oe <= '0;
    end else begin
      gen_pin_oe <= casc & {2{~slave}}; // RL2 RL6
    end
  end

  // Edge on the unmaskable line; a new edge wins over delivery
  always_ff @(posedge mclk) begin
    if (rst) begin
      nmi_d    <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      nmi_d <= nmi_f;
      if (nmi_f && !nmi_d) begin
        nmi_pend <= 1'b1; // RL1
      end else if (state == ST_IDLE && ack_core) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

  function automatic logic [DW-1:0] reg_rd(input logic [AW-1:0] a);
    logic [DW-1:0]   r;
    logic [IDXW-1:0] i;
    r = '0;
    i = a[CI_LSB +: IDXW];
    if (a[AW-1:CI_LSB] < (AW-CI_LSB)'(NSRC)) begin
      r[CF_PRIO +: PW] = prio[i];
      r[CF_OFF]        = src_off[i];
      if (i == IDXW'(SRC_EXT0)) r[CF_CASC] = casc[0];
      if (i == IDXW'(SRC_EXT1)) r[CF_CASC] = casc[1];
    end else begin
      case (a)
        OFF_ISR:   r[NSRC-1:0]  = is_flag;
        OFF_IMASK: r[NSRC-1:0]  = imask;
        OFF_STAT:  r[NST-1:0]   = stat;
        OFF_SMASK: r[NST-1:0]   = smask;
        OFF_RELOC: r[RELOC_SLAVE] = slave;
        OFF_PEND:  r[NSRC-1:0]  = req_raw;
        default:   r = '0;
      endcase
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return a[1:0] == 2'h0 && (a[AW-1:CI_LSB] < (AW-CI_LSB)'(NSRC) ||
           a == OFF_ISR || a == OFF_EOI || a == OFF_IMASK || a == OFF_STAT ||
           a == OFF_SMASK || a == OFF_RELOC || a == OFF_PEND);
  endfunction

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bm[b*8 +: 8] = {8{w_s[b]}};
    end
    w_new = (reg_rd(aw_a) & ~bm) | (w_d & bm);
    w_one = w_d & bm;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_a          <= '0;
      w_d           <= '0;
      w_s           <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready) || wr_fire;
      s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready) || wr_fire;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_a    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_d    <= s_axi_wdata;
        w_s    <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_a) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        prio[i] <= DEF_PRIO[i*PW +: PW]; // RL12
      end
      src_off <= '0;
      casc    <= '0;
      imask   <= '0;
      smask   <= '0;
      slave   <= 1'b0;
    end else if (wr_fire && mapped(aw_a)) begin
      if (aw_a[AW-1:CI_LSB] < (AW-CI_LSB)'(NSRC)) begin
        prio[aw_a[CI_LSB +: IDXW]]    <= w_new[CF_PRIO +: PW]; // RL10
        src_off[aw_a[CI_LSB +: IDXW]] <= w_new[CF_OFF]; // RL15
        if (aw_a[CI_LSB +: IDXW] == IDXW'(SRC_EXT0)) casc[0] <= w_new[CF_CASC]; // RL6
        if (aw_a[CI_LSB +: IDXW] == IDXW'(SRC_EXT1)) casc[1] <= w_new[CF_CASC]; // RL6
      end
      if (aw_a == OFF_IMASK) imask <= w_new[NSRC-1:0]; // RL15
      if (aw_a == OFF_SMASK) smask <= w_new[NST-1:0];
      if (aw_a == OFF_RELOC) slave <= w_new[RELOC_SLAVE]; // RL16
    end
  end

  // In-service flags; a fresh acknowledge wins over an end-of-interrupt
  always_comb begin
    is_set = '0;
    if (take) is_set[pend_bus.idx] = 1'b1; // RL18
    is_clr = (wr_fire && aw_a == OFF_EOI) ? w_one[NSRC-1:0] : '0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      is_flag <= '0;
    end else begin
      is_flag <= (is_flag & ~is_clr) | is_set; // RL18
    end
  end

  // Sticky event status, write one to clear, set beats clear
  always_comb begin
    ev             = '0;
    ev[ST_NMI]     = nmi_f && !nmi_d;
    ev[ST_VEC]     = vec_valid;
    ev[ST_EOI_ERR] = |(is_clr & ~is_flag);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stat    <= '0;
      int_out <= 1'b0;
    end else begin
      if (wr_fire && aw_a == OFF_STAT) begin
        stat <= (stat & ~w_one[NST-1:0]) | ev;
      end else begin
        stat <= stat | ev;
      end
      int_out <= |(stat & smask);
    end
  end

  // AXI4-Lite read side, one read at a time
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= mapped(s_axi_araddr) ? reg_rd(s_axi_araddr) : '0;
        s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  sequence s_ack_pair;
    ack_act [*6] ##1 !ack_act [*2] ##1 ack_act [*6];
  endsequence

  sequence s_casc_start;
    take && casc_sel;
  endsequence

  chk_casc_two_acks: assert property ( // RL4
    s_casc_start |=> s_ack_pair ##1 (!ack_act && vec_valid))
    else $error("cascade acknowledge is not two pulses");

  chk_casc_vector_src: assert property ( // RL3
    (state == ST_ACK2 && cnt == ACK_LEN - 1'b1) |=> vec_out == $past(cvec_f))
    else $error("cascade vector not from pins");

  chk_nmi_unmaskable: assert property ( // RL1
    (state == ST_IDLE && ack_core && nmi_pend) |=> vec_valid && vec_out == NMI_VEC)
    else $error("non-maskable vector not delivered");

  chk_ack_sets_flag: assert property ( // RL18
    take |=> is_flag[$past(pend_bus.idx)])
    else $error("in-service flag not set on acknowledge");

  chk_eoi_clears_flag: assert property ( // RL18
    (is_clr != '0 && !take) |=> (is_flag & $past(is_clr)) == '0)
    else $error("end-of-interrupt did not clear flag");

  chk_lower_blocked: assert property ( // RL8
    (is_bus.valid && pend_bus.valid && win_lvl >= is_lvl && !nmi_pend) |=> !irq_core)
    else $error("lower priority interrupted service");

  chk_same_src_quiet: assert property ( // RL9
    is_flag[$past(pend_bus.idx)] |-> !($past(take) && $past(is_flag[pend_bus.idx])))
    else $error("source in service acknowledged again");

  chk_direct_vector: assert property ( // RL7
    (take && !casc_sel) |=> vec_valid && vec_out == VEC_BASE + VW'($past(pend_bus.idx)))
    else $error("internal vector wrong");

  chk_slave_ignores_pins: assert property ( // RL16
    slave |-> req_raw[SRC_EXT3:SRC_EXT0] == '0)
    else $error("external pins active in slave mode");

  chk_irq_level: assert property (
    ((stat & smask) != '0) |=> int_out)
    else $error("interrupt output not raised");
endmodule

//--- hw/nic_pkg.sv
/*
  Shared constants of the nested priority interrupt controller:
  register map, field positions, source numbering, timing counts.
  Assumes a 32-bit AXI4-Lite register port with byte addressing.
*/
package nic_pkg;
  localparam int NSRC = 7;
  localparam int IDXW = 3;
  localparam int PW   = 3;
  localparam int KW   = 6;
  localparam int VW   = 8;
  localparam int AW   = 8;
  localparam int DW   = 32;
  localparam int SRC_TMR  = 0;
  localparam int SRC_DMA0 = 1;
  localparam int SRC_DMA1 = 2;
  localparam int SRC_EXT0 = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_EXT2 = 5;
  localparam int SRC_EXT3 = 6;
  localparam logic [AW-1:0] OFF_EOI   = 8'h24;
  localparam logic [AW-1:0] OFF_ISR   = 8'h20;
  localparam logic [AW-1:0] OFF_IMASK = 8'h28;
  localparam logic [AW-1:0] OFF_STAT  = 8'h2C;
  localparam logic [AW-1:0] OFF_SMASK = 8'h30;
  localparam logic [AW-1:0] OFF_RELOC = 8'h34;
  localparam logic [AW-1:0] OFF_PEND  = 8'h38;
  localparam int CI_LSB  = 2;
  localparam int CF_PRIO = 0;
  localparam int CF_OFF  = 3;
  localparam int CF_CASC = 4;
  localparam int RELOC_SLAVE = 14;
  localparam int NST        = 3;
  localparam int ST_NMI     = 0;
  localparam int ST_VEC     = 1;
  localparam int ST_EOI_ERR = 2;
  localparam int SY_NMI = 0;
  localparam int SY_GEN = 1;
  localparam int SY_VEC = 5;
  localparam int SYW    = 13;
  localparam int CNTW   = 3;
  localparam logic [CNTW-1:0] ACK_LEN = 3'h6;
  localparam logic [CNTW-1:0] ACK_GAP = 3'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACK1 = 4'h2,
    ST_GAP  = 4'h4,
    ST_ACK2 = 4'h8
  } nic_state_t;
endpackage

//--- testbench/nic_ctrl_bench.sv
/*
  Self-checking bench of the interrupt controller.
  Assumes the pin synchronisers settle within six cycles.
*/
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module nic_ctrl_bench
  import nic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [VW-1:0] VB = 8'h20;
  localparam logic [VW-1:0] CV = 8'h9c;
  localparam logic [VW-1:0] CV1 = 8'h5a;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [DW-1:0] wdata = '0, rdata;
  logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic          ack = 0, nmi = 0, tmr = 0;
  logic          awready, wready, bvalid, arready, rvalid, irq, vvalid, intr;
  logic [1:0]    bresp, rresp, pout, poe;
  logic [1:0]    dma = '0;
  logic [3:0]    pin = '0;
  logic [VW-1:0] cv0, cv1, vout, ve;
  logic [33:0]   re;
  logic [1:0]    be;
  logic          vsel = 1'b0;
  logic [2:0]    la, lb;
  int            errors = 0, checks_done = 0, k;
  logic [VW-1:0] vq[$];
  logic [33:0]   rq[$];
  logic [1:0]    bq[$];
  // The split pins 2 and 3 show the acknowledge whenever the controller drives them
  wire logic [3:0] gpin = {poe[1] ? pout[1] : pin[3], poe[0] ? pout[0] : pin[2], pin[1:0]};
  // Both pairs share one vector bus; the scenario picks which far-side controller drives it
  wire logic [VW-1:0] cvec = vsel ? cv1 : cv0;
  always #2.5 mclk = ~mclk;
  nic_ctrl #(.VEC_BASE(VB), .NMI_VEC(8'h02)) dut (.mclk(mclk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tmr_req(tmr), .dma_req(dma), .nmi_pin(nmi), .gen_pin_in(gpin), .gen_pin_out(pout),
    .gen_pin_oe(poe), .casc_vec_pin(cvec), .irq_core(irq), .ack_core(ack),
    .vec_out(vout), .vec_valid(vvalid), .int_out(intr));
  nic_ext_model #(.VEC(CV)) ext (.mclk(mclk), .rst(rst), .ack(pout[0] & poe[0]), .vec(cv0));
  nic_ext_model #(.VEC(CV1)) ext_b (.mclk(mclk), .rst(rst),
    .ack(pout[1] & poe[1]), .vec(cv1));
  // Pop once before comparing, the macro evaluates its arguments twice
  always @(posedge mclk) begin
    if (vvalid === 1'b1) begin
      if (vq.size() == 0) `CHK(vvalid, 1'b0)
      else begin
        ve = vq.pop_front();
        `CHK(vout, ve)
      end
    end
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
      be = bq.pop_front();
      `CHK(bresp, be)
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
      re = rq.pop_front();
      `CHK({rresp, rdata}, re)
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("Error t=%0t wait ran out", $time);
    end_of_test();
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(er);
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 50) tmo();
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [33:0] e);
    int i;
    @(posedge mclk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 50) tmo();
  endtask
  task automatic see_irq(input logic e);
    int i;
    for (i = 0; i < 12 && irq !== 1'b1; i++) @(posedge mclk);
    `CHK(irq, e)
  endtask
  task automatic take(input logic [VW-1:0] v);
    int i;
    vq.push_back(v);
    @(posedge mclk);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    for (i = 0; i < 30 && vq.size() > 0; i++) @(posedge mclk);
    if (vq.size() > 0) tmo();
  endtask
  task automatic drop_eoi(input logic [DW-1:0] m);
    tmr <= 1'b0;
    dma <= 2'b00;
    pin <= 4'h0;
    repeat (6) @(posedge mclk);
    wr(OFF_EOI, m, RESP_OKAY);
  endtask
  initial begin
    void'($urandom(32'h5872_2bb8));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(8'h00, {RESP_OKAY, 32'h0000_0007});
    rd(8'hfc, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h50, 32'h0000_0001, RESP_SLVERR);
    tmr <= 1'b1;
    dma <= 2'b01;
    see_irq(1'b1);
    take(VB);
    see_irq(1'b0);
    drop_eoi(32'h0000_0001);
    wr(8'h0c, 32'h0000_0005, RESP_OKAY);
    wr(8'h10, 32'h0000_0002, RESP_OKAY);
    pin <= 4'b0001;
    see_irq(1'b1);
    take(VB + 8'h03);
    tmr <= 1'b1;
    see_irq(1'b0);
    pin <= 4'b0011;
    see_irq(1'b1);
    take(VB + 8'h04);
    rd(OFF_ISR, {RESP_OKAY, 32'h0000_0018});
    drop_eoi(32'h0000_0018);
    see_irq(1'b0);
    wr(OFF_IMASK, 32'h0000_0001, RESP_OKAY);
    wr(8'h08, 32'h0000_000f, RESP_OKAY);
    tmr <= 1'b1;
    dma <= 2'b10;
    see_irq(1'b0);
    wr(OFF_IMASK, 32'h0000_0000, RESP_OKAY);
    see_irq(1'b1);
    take(VB);
    drop_eoi(32'h0000_0001);
    for (k = 0; k < 4; k++) begin
      la = 3'($urandom_range(7, 0));
      lb = 3'($urandom_range(7, 0));
      wr(8'h0c, {29'h0, la}, RESP_OKAY);
      wr(8'h10, {29'h0, lb}, RESP_OKAY);
      pin <= 4'b0011;
      see_irq(1'b1);
      take((lb < la) ? VB + 8'h04 : VB + 8'h03);
      see_irq(1'b0);
      drop_eoi(32'h0000_0018);
    end
    wr(8'h0c, 32'h0000_0013, RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK(poe, 2'b01)
    pin <= 4'b0001;
    see_irq(1'b1);
    take(CV);
    drop_eoi(32'h0000_0008);
    wr(8'h10, 32'h0000_0012, RESP_OKAY);
    vsel <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(poe, 2'b11)
    pin <= 4'b0010;
    see_irq(1'b1);
    take(CV1);
    drop_eoi(32'h0000_0010);
    wr(OFF_STAT, 32'h0000_0007, RESP_OKAY);
    wr(OFF_SMASK, 32'h0000_0001, RESP_OKAY);
    wr(OFF_IMASK, 32'h0000_007f, RESP_OKAY);
    nmi <= 1'b1;
    see_irq(1'b1);
    take(8'h02);
    `CHK(intr, 1'b1)
    rd(OFF_STAT, {RESP_OKAY, 32'h0000_0003});
    wr(OFF_STAT, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge mclk);
    // Delivered-vector status stays set but is masked off the line
    `CHK(intr, 1'b0)
    rd(OFF_STAT, {RESP_OKAY, 32'h0000_0002});
    nmi <= 1'b0;
    wr(OFF_IMASK, 32'h0000_0000, RESP_OKAY);
    wr(OFF_RELOC, 32'h0000_4000, RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK(poe, 2'b00)
    pin <= 4'b0010;
    see_irq(1'b0);
    tmr <= 1'b1;
    see_irq(1'b1);
    take(VB);
    // Timer still requests but is in service, so the core gets the spurious vector
    take(8'hff);
    end_of_test();
  end
endmodule

//--- testbench/nic_ext_model.sv
/*
  External cascaded controller behind one acknowledge pair.
  Assumes two acknowledge bursts per cascaded acknowledge.
*/
module nic_ext_model #(
  parameter logic [7:0] VEC = 8'h9c
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ack,
  output logic [7:0]      vec
);
  logic [1:0] cnt;
  logic [1:0] tail;
  logic       ack_d;
  logic [7:0] junk = ~VEC;
  // Outside the second burst and the three cycles after it the bus keeps changing, so an early or late capture fails
  assign vec = ((ack && !ack_d && cnt == 2'd1) || cnt == 2'd2) ? VEC : junk;
  always @(posedge mclk) begin
    ack_d <= ack;
    junk <= junk ^ 8'h01;
    if (rst) begin
      cnt <= 2'd0;
      tail <= 2'd0;
    end else if (ack && !ack_d) begin
      cnt <= cnt + 2'd1;
    end else if (!ack && ack_d && cnt == 2'd2) begin
      tail <= 2'd2;
    end else if (tail != 2'd0) begin
      tail <= tail - 2'd1;
      if (tail == 2'd1) cnt <= 2'd0;
    end
  end
endmodule
